// >>> inc/pcm_regs.vh
`ifndef PCM_REGS_VH
`define PCM_REGS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define PCM_ADDR_W           4
`define PCM_OFS_CTRL         4'h0
`define PCM_OFS_STATUS       4'h4
`define PCM_OFS_MASK         4'h8
`define PCM_OFS_STATE        4'hC

// ****************************************************************
// control fields
// ****************************************************************
`define PCM_CTRL_W           6
`define PCM_CTRL_RESET       6'h33
`define PCM_CTRL_CAM_EN      0
`define PCM_CTRL_BOT_EN      1
`define PCM_CTRL_BOT_RANGE   2
`define PCM_CTRL_MIN_LONG    3
`define PCM_CTRL_RST_EN      4
`define PCM_CTRL_DIS_EN      5

// ****************************************************************
// status and mask fields
// ****************************************************************
`define PCM_EVT_W            4
`define PCM_EVT_RESET        4'h0
`define PCM_EVT_CONTACT      0
`define PCM_EVT_OVERRUN      1
`define PCM_EVT_RST_OK       2
`define PCM_EVT_RESTART      3

// ****************************************************************
// input vector positions
// ****************************************************************
`define PCM_IN_W             6
// cam contact idles closed: its stages start high, no false fall
`define PCM_IN_RESET         6'h04
`define PCM_IN_TOP           0
`define PCM_IN_BOT           1
`define PCM_IN_CAM           2
`define PCM_IN_DRV           3
`define PCM_IN_DIS           4
`define PCM_IN_RST           5

// ****************************************************************
// timing
// ****************************************************************
`define PCM_CLK_PERIOD_NS    10
`define PCM_MS_NS            1000000
`define PCM_MS_CYCLES        (`PCM_MS_NS / `PCM_CLK_PERIOD_NS)
`define PCM_MS_W             15
`define PCM_RST_MIN_SHORT_MS 15'd100
`define PCM_RST_MIN_LONG_MS  15'd350
`define PCM_RST_MAX_MS       15'd30000
`define PCM_BOT_ONE          2'h1
`define PCM_BOT_TWO          2'h2
`define PCM_CNT_ZERO         2'h0

`endif

// >>> hw/pcm_pulse_qual.v
`timescale 1ns/1ps
`include "pcm_regs.vh"

// ****************************************************************
// reset pulse qualifier, counts high time in whole ms ticks
// ****************************************************************
module pcm_pulse_qual (
   input  wire                 sys_clk,
   input  wire                 resetn,
   input  wire                 ms_tick,
   input  wire                 level,
   input  wire                 min_long,
   output reg                  accept
);

   reg  [`PCM_MS_W-1:0] high_ms_reg;
   reg                  level_prev_reg;
   wire [`PCM_MS_W-1:0] min_ms;
   wire                 fall;
   wire                 over;

   assign min_ms = min_long ? `PCM_RST_MIN_LONG_MS : `PCM_RST_MIN_SHORT_MS;
   assign fall   = level_prev_reg & ~level;
   // saturate one past the limit so an overlong pulse stays refused
   assign over   = (high_ms_reg > `PCM_RST_MAX_MS);

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         high_ms_reg    <= {`PCM_MS_W{1'b0}};
         level_prev_reg <= 1'b0;
         accept         <= 1'b0;
      end else begin
         level_prev_reg <= level;
         accept         <= fall & ~over & (high_ms_reg >= min_ms);
         if (!level) begin
            high_ms_reg <= {`PCM_MS_W{1'b0}};
         end else if (ms_tick && !over) begin
            high_ms_reg <= high_ms_reg + {{(`PCM_MS_W-1){1'b0}}, 1'b1};
         end
      end
   end

endmodule // pcm_pulse_qual

// >>> hw/pcm_monitor.v
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "pcm_regs.vh"

// Function
// - in zero-to-two mode every bottom pulse is checked except the prior cam fall need.
// - bottom pulses per cycle must be exactly one, or zero to two in range mode.
// - any sequence or count violation drops release and raises contact error.
// - overrun supervision runs only with the safety cam contact enabled.
// - drive released must rise after top output rises or be high at the cam fall.
// - disable high with no error holds release low and suspends supervision.
// - disable high with an error pending still lets that error be reset.
// - disable falling restarts the block from a fresh start state.
// - an error reset is a low-high-low pulse of 100 or 350 ms up to 30 s.
// - an error drops release, sets its error output and reset required.
// - upstroke rises on a bottom rise and falls on the first top or bottom fall.
module pcm_monitor #(
   parameter CYC_PER_MS = `PCM_MS_CYCLES,
   parameter MS_DIV_W   = 17
) (
   input  wire                   sys_clk,
   input  wire                   resetn,
   input  wire                   top_dead_centre_contact,
   input  wire                   bottom_dead_centre_contact,
   input  wire                   safety_cam_contact,
   input  wire                   drive_released,
   input  wire                   disable_monitoring,
   input  wire                   reset_pulse,
   input  wire [`PCM_ADDR_W-1:0] reg_addr,
   input  wire [31:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [31:0]            reg_rdata,
   output reg                    release_out,
   output reg                    contact_error,
   output reg                    overrun_error,
   output reg                    reset_required,
   output reg                    top_out,
   output reg                    upstroke,
   output reg                    irq
);

   // ****************************************************************
   // helpers
   // ****************************************************************
   function rise;
      input cur;
      input prev;
      begin
         rise = cur & ~prev;
      end
   endfunction

   function fall;
      input cur;
      input prev;
      begin
         fall = ~cur & prev;
      end
   endfunction

   // ****************************************************************
   // input synchronisers and previous samples
   // ****************************************************************
   reg  [`PCM_IN_W-1:0] in_s1_reg;
   reg  [`PCM_IN_W-1:0] in_s2_reg;
   reg  [`PCM_IN_W-1:0] in_prev_reg;
   wire [`PCM_IN_W-1:0] in_raw;

   assign in_raw = {reset_pulse, disable_monitoring, drive_released,
                    safety_cam_contact, bottom_dead_centre_contact,
                    top_dead_centre_contact};

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         in_s1_reg   <= `PCM_IN_RESET;
         in_s2_reg   <= `PCM_IN_RESET;
         in_prev_reg <= `PCM_IN_RESET;
      end else begin
         in_s1_reg   <= in_raw;
         in_s2_reg   <= in_s1_reg;
         in_prev_reg <= in_s2_reg;
      end
   end

   wire t  = in_s2_reg[`PCM_IN_TOP];
   wire b  = in_s2_reg[`PCM_IN_BOT];
   wire s  = in_s2_reg[`PCM_IN_CAM];
   wire d  = in_s2_reg[`PCM_IN_DRV];
   wire dm = in_s2_reg[`PCM_IN_DIS];
   wire rs = in_s2_reg[`PCM_IN_RST];

   wire tr = rise(t, in_prev_reg[`PCM_IN_TOP]);
   wire tf = fall(t, in_prev_reg[`PCM_IN_TOP]);
   wire br = rise(b, in_prev_reg[`PCM_IN_BOT]);
   wire bf = fall(b, in_prev_reg[`PCM_IN_BOT]);
   wire sf = fall(s, in_prev_reg[`PCM_IN_CAM]);
   wire dr = rise(d, in_prev_reg[`PCM_IN_DRV]);

   // ****************************************************************
   // register file
   // ****************************************************************
   reg  [`PCM_CTRL_W-1:0] ctrl_reg;
   reg  [`PCM_EVT_W-1:0]  status_reg;
   reg  [`PCM_EVT_W-1:0]  mask_reg;
   reg  [`PCM_EVT_W-1:0]  status_next;
   wire [`PCM_EVT_W-1:0]  events;

   wire cam_en    = ctrl_reg[`PCM_CTRL_CAM_EN];
   wire bot_en    = ctrl_reg[`PCM_CTRL_BOT_EN];
   wire bot_range = ctrl_reg[`PCM_CTRL_BOT_RANGE];
   wire min_long  = ctrl_reg[`PCM_CTRL_MIN_LONG];
   wire rst_en    = ctrl_reg[`PCM_CTRL_RST_EN];
   wire dis_act   = ctrl_reg[`PCM_CTRL_DIS_EN] & dm;

   // ****************************************************************
   // millisecond enable and reset pulse qualifier
   // ****************************************************************
   reg  [MS_DIV_W-1:0] ms_div_reg;
   reg                 ms_tick_reg;
   wire                rst_accept;

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ms_div_reg  <= {MS_DIV_W{1'b0}};
         ms_tick_reg <= 1'b0;
      end else if (ms_div_reg == CYC_PER_MS[MS_DIV_W-1:0] - 1'b1) begin
         ms_div_reg  <= {MS_DIV_W{1'b0}};
         ms_tick_reg <= 1'b1;
      end else begin
         ms_div_reg  <= ms_div_reg + {{(MS_DIV_W-1){1'b0}}, 1'b1};
         ms_tick_reg <= 1'b0;
      end
   end

   pcm_pulse_qual u_rst_qual (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .ms_tick  (ms_tick_reg),
      .level    (rs),
      .min_long (min_long),
      .accept   (rst_accept)
   );

   // ****************************************************************
   // supervision state
   // ****************************************************************
   reg       armed_reg;
   reg       cyc_valid_reg;
   reg       cam_fell_reg;
   reg       drv_seen_reg;
   reg       up_taken_reg;
   reg       up_block_reg;
   reg [1:0] bot_cnt_reg;

   wire err      = contact_error | overrun_error;
   // supervision only while armed, error free and not disabled
   wire mon      = armed_reg & ~err & ~dis_act;
   wire bot_max  = bot_range ? (bot_cnt_reg == `PCM_BOT_TWO)
                             : (bot_cnt_reg == `PCM_BOT_ONE);
   wire bot_none = (bot_cnt_reg == `PCM_CNT_ZERO) & ~br;

   reg v_contact;
   reg v_overrun;

   always @* begin
      v_contact = 1'b0;
      v_overrun = 1'b0;
      if (mon) begin
         if (cam_en) begin
            if (sf && !t)
               v_contact = 1'b1;
            if (!t && !s)
               v_contact = 1'b1;
            if (sf && cyc_valid_reg && cam_fell_reg)
               v_contact = 1'b1;
            if (tf && cyc_valid_reg && !cam_fell_reg)
               v_contact = 1'b1;
            // either a drive rise since top output rose, or high now
            if (sf && !(drv_seen_reg || d))
               v_overrun = 1'b1;
         end
         if (bot_en) begin
            if (br && !t)
               v_contact = 1'b1;
            if (cam_en && !bot_range && br && cyc_valid_reg
                && !cam_fell_reg)
               v_contact = 1'b1;
            if (cam_en && sf && b)
               v_contact = 1'b1;
            if (!cam_en && tr && b)
               v_contact = 1'b1;
            if (br && cyc_valid_reg && bot_max)
               v_contact = 1'b1;
            if (tf && cyc_valid_reg && !bot_range && bot_none)
               v_contact = 1'b1;
         end
      end
   end

   // ****************************************************************
   // next values
   // ****************************************************************
   wire clr_err   = rst_en & rst_accept;
   wire cont_next = (contact_error | v_contact) & ~clr_err;
   wire ovr_next  = (overrun_error | v_overrun) & ~clr_err;
   wire err_next  = cont_next | ovr_next;
   // disable falling or error cleared re-arms next cycle from scratch
   wire arm_next  = ~err_next & ~dis_act;
   wire fresh     = ~armed_reg & arm_next;

   wire up_accept = mon & bot_en & br & ~up_taken_reg & ~up_block_reg;
   reg  up_next;

   always @* begin
      if (err_next) begin
         up_next = 1'b0;
      end else if (upstroke && (tf || bf)) begin
         up_next = 1'b0;
      end else if (up_accept) begin
         up_next = 1'b1;
      end else begin
         up_next = upstroke;
      end
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         armed_reg     <= 1'b0;
         cyc_valid_reg <= 1'b0;
         cam_fell_reg  <= 1'b0;
         drv_seen_reg  <= 1'b0;
         up_taken_reg  <= 1'b0;
         up_block_reg  <= 1'b0;
         bot_cnt_reg   <= `PCM_CNT_ZERO;
      end else begin
         armed_reg <= arm_next;
         if (fresh) begin
            cyc_valid_reg <= 1'b0;
            cam_fell_reg  <= 1'b0;
            drv_seen_reg  <= 1'b0;
            up_taken_reg  <= 1'b0;
            // bottom already made at start: no upstroke this cycle
            up_block_reg  <= b;
            bot_cnt_reg   <= `PCM_CNT_ZERO;
         end else begin
            if (tr) begin
               cyc_valid_reg <= 1'b1;
               cam_fell_reg  <= 1'b0;
               up_taken_reg  <= 1'b0;
               up_block_reg  <= 1'b0;
               bot_cnt_reg   <= `PCM_CNT_ZERO;
            end else begin
               if (sf)
                  cam_fell_reg <= 1'b1;
               if (up_accept)
                  up_taken_reg <= 1'b1;
               if (br && !bot_cnt_reg[1])
                  bot_cnt_reg <= bot_cnt_reg + `PCM_BOT_ONE;
            end
            // set wins: a drive rise in the clearing cycle is kept
            if (dr)
               drv_seen_reg <= 1'b1;
            else if (tf)
               drv_seen_reg <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         release_out    <= 1'b0;
         contact_error  <= 1'b0;
         overrun_error  <= 1'b0;
         reset_required <= 1'b0;
         top_out        <= 1'b0;
         upstroke       <= 1'b0;
      end else begin
         release_out    <= armed_reg & arm_next;
         contact_error  <= cont_next;
         overrun_error  <= ovr_next;
         reset_required <= err_next;
         top_out        <= ~err_next & ~t;
         upstroke       <= up_next;
      end
   end

   // ****************************************************************
   // events, status, mask and interrupt
   // ****************************************************************
   assign events = {fresh, clr_err & err, v_overrun, v_contact};

   wire st_rd = reg_rd & (reg_addr == `PCM_OFS_STATUS);

   always @* begin
      status_next = status_reg;
      if (st_rd)
         status_next = `PCM_EVT_RESET;
      // set wins over the read clear
      status_next = status_next | events;
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg   <= `PCM_CTRL_RESET;
         mask_reg   <= `PCM_EVT_RESET;
         status_reg <= `PCM_EVT_RESET;
         irq        <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `PCM_OFS_CTRL)
            ctrl_reg <= reg_wdata[`PCM_CTRL_W-1:0];
         if (reg_wr && reg_addr == `PCM_OFS_MASK)
            mask_reg <= reg_wdata[`PCM_EVT_W-1:0];
         status_reg <= status_next;
         irq        <= |(status_next & mask_reg);
      end
   end

   // ****************************************************************
   // read port, data in the cycle after the strobe
   // ****************************************************************
   reg [31:0] rd_mux;

   always @* begin
      case (reg_addr)
         `PCM_OFS_CTRL: begin
            rd_mux = {{(32-`PCM_CTRL_W){1'b0}}, ctrl_reg};
         end
         `PCM_OFS_STATUS: begin
            rd_mux = {{(32-`PCM_EVT_W){1'b0}}, status_reg};
         end
         `PCM_OFS_MASK: begin
            rd_mux = {{(32-`PCM_EVT_W){1'b0}}, mask_reg};
         end
         `PCM_OFS_STATE: begin
            rd_mux = {22'h000000, bot_cnt_reg, cyc_valid_reg, armed_reg,
                      upstroke, top_out, reset_required, overrun_error,
                      contact_error, release_out};
         end
         default: begin
            rd_mux = 32'h00000000;
         end
      endcase
   end

   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= 32'h00000000;
      end
   end

endmodule // pcm_monitor

// >>> sim/pcm_press_model.sv
`timescale 1ns/1ps

// ****************************************************************
// press cam switches and drive control
// ****************************************************************
module pcm_press_model (
   input  wire logic       sys_clk,
   input  wire logic       go,
   input  wire logic [2:0] kind,
   input  wire logic       slow,
   output logic            top,
   output logic            bot,
   output logic            cam,
   output logic            drv,
   output logic            busy
);
   // kinds: 0 legal, 1 two bottom pulses, 2 none, 3 bottom early,
   // 4 drive never released
   task automatic hold();
      repeat (slow ? 40 : 8) @(posedge sys_clk);
   endtask

   initial begin
      top = 1'b0;
      bot = 1'b0;
      cam = 1'b1;
      drv = 1'b0;
      busy = 1'b0;
      forever begin
         @(posedge sys_clk);
         if (go) begin
            busy <= 1'b1;
            top <= 1'b1;
            hold();
            if (kind != 3'd4) drv <= 1'b1;
            hold();
            if (kind == 3'd3) begin
               bot <= 1'b1;
               hold();
            end
            cam <= 1'b0;
            hold();
            if (kind != 3'd2 && kind != 3'd3) begin
               bot <= 1'b1;
               hold();
            end
            if (kind == 3'd1) begin
               bot <= 1'b0;
               hold();
               bot <= 1'b1;
               hold();
            end
            cam <= 1'b1;
            hold();
            top <= 1'b0;
            hold();
            bot <= 1'b0;
            drv <= 1'b0;
            hold();
            busy <= 1'b0;
         end
      end
   end
endmodule // pcm_press_model

// >>> sim/pcm_monitor_chk.sv
`timescale 1ns/1ps

// ****************************************************************
// port checker for the contact monitor
// ****************************************************************
module pcm_monitor_chk (
   input  wire logic sys_clk,
   input  wire logic resetn,
   input  wire logic top_dead_centre_contact,
   input  wire logic bottom_dead_centre_contact,
   input  wire logic disable_monitoring,
   input  wire logic reset_pulse,
   input  wire logic release_out,
   input  wire logic contact_error,
   input  wire logic overrun_error,
   input  wire logic reset_required,
   input  wire logic top_out,
   input  wire logic upstroke
);
   logic [4:0] rst_low_reg;
   logic [2:0] bot_hi_reg;
   logic [2:0] dis_hi_reg;

   // saturating counters, margin covers the input synchroniser
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rst_low_reg <= 5'h0;
         bot_hi_reg <= 3'h0;
         dis_hi_reg <= 3'h0;
      end else begin
         rst_low_reg <= reset_pulse ? 5'h0 :
                        (rst_low_reg == 5'h1F ? 5'h1F : rst_low_reg + 5'h1);
         bot_hi_reg <= !bottom_dead_centre_contact ? 3'h0 :
                       (bot_hi_reg == 3'h7 ? 3'h7 : bot_hi_reg + 3'h1);
         dis_hi_reg <= !disable_monitoring ? 3'h0 :
                       (dis_hi_reg == 3'h7 ? 3'h7 : dis_hi_reg + 3'h1);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence top_hi_s; top_dead_centre_contact [*6]; endsequence
   sequence top_lo_s; (!top_dead_centre_contact) [*6]; endsequence
   sequence bot_lo_s; (!bottom_dead_centre_contact) [*6]; endsequence

   err_release_a: assert property (
      (contact_error || overrun_error) |-> !release_out)
      else $error("release high while an error is pending");
   req_err_a: assert property (
      reset_required == (contact_error || overrun_error))
      else $error("reset required differs from error state");
   err_outputs_a: assert property (
      reset_required |-> (!top_out && !upstroke))
      else $error("top or upstroke high during error");
   err_sticky_a: assert property (
      (reset_required && rst_low_reg > 5'd12) |=> reset_required)
      else $error("error cleared without a reset pulse");
   dis_release_a: assert property (
      (dis_hi_reg >= 3'd6) |-> !release_out)
      else $error("release high while monitoring disabled");
   restart_a: assert property (
      ($fell(disable_monitoring) && !reset_required) |-> ##[1:12] release_out)
      else $error("release did not return after disable");
   top_out_a: assert property (
      top_hi_s |-> !top_out)
      else $error("top output high with top contact high");
   up_top_a: assert property (
      top_lo_s |-> !upstroke)
      else $error("upstroke held with top contact low");
   up_bot_a: assert property (
      bot_lo_s |-> !upstroke)
      else $error("upstroke held with bottom contact low");
   up_rise_a: assert property (
      $rose(upstroke) |-> bot_hi_reg >= 3'd2)
      else $error("upstroke rose without bottom contact");
endmodule // pcm_monitor_chk

// >>> sim/testbench.sv
`timescale 1ns/1ps
`include "pcm_regs.vh"

// ****************************************************************
// top bench
// ****************************************************************
module testbench;
   typedef struct packed {
      logic [2:0] kind;
      logic       slow;
      logic [5:0] ctrl;
      logic       cerr;
      logic       oerr;
   } pcm_row_t;

   logic                   sys_clk, resetn, dis_mon, rst_pulse;
   logic                   reg_wr, reg_rd, go, slow;
   logic [2:0]             kind;
   logic [`PCM_ADDR_W-1:0] reg_addr;
   logic [31:0]            reg_wdata, reg_rdata, d;
   logic                   top, bot, cam, drv, busy;
   logic                   rel, cerr, oerr, rreq, top_o, up, irq;
   int                     err_count, check_count;
   pcm_row_t               rows [0:8] = '{
      '{3'd0, 1'b0, 6'h33, 1'b0, 1'b0}, '{3'd1, 1'b0, 6'h33, 1'b1, 1'b0},
      '{3'd1, 1'b0, 6'h37, 1'b0, 1'b0}, '{3'd2, 1'b0, 6'h37, 1'b0, 1'b0},
      '{3'd2, 1'b0, 6'h33, 1'b1, 1'b0}, '{3'd3, 1'b0, 6'h37, 1'b1, 1'b0},
      '{3'd4, 1'b0, 6'h3B, 1'b0, 1'b1}, '{3'd4, 1'b0, 6'h32, 1'b0, 1'b0},
      '{3'd0, 1'b1, 6'h33, 1'b0, 1'b0}};

   pcm_press_model pcm_press_model_i (.sys_clk(sys_clk), .go(go),
      .kind(kind), .slow(slow), .top(top), .bot(bot), .cam(cam),
      .drv(drv), .busy(busy));

   // ms shortened to 10 cycles so reset pulses stay short
   pcm_monitor #(.CYC_PER_MS(10)) pcm_monitor_i (.sys_clk(sys_clk),
      .resetn(resetn), .top_dead_centre_contact(top),
      .bottom_dead_centre_contact(bot), .safety_cam_contact(cam),
      .drive_released(drv), .disable_monitoring(dis_mon),
      .reset_pulse(rst_pulse), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .release_out(rel), .contact_error(cerr), .overrun_error(oerr),
      .reset_required(rreq), .top_out(top_o), .upstroke(up), .irq(irq));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (err_count == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      // data stand only in the cycle after the strobe
      @(posedge sys_clk);
      v = reg_rdata;
   endtask

   task automatic run_press(input logic [2:0] k, input logic s);
      @(posedge sys_clk);
      go <= 1'b1;
      kind <= k;
      slow <= s;
      @(posedge sys_clk);
      go <= 1'b0;
      // busy is only visible one edge after the model took go
      @(posedge sys_clk);
      while (busy) @(posedge sys_clk);
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic pulse(input int n);
      @(posedge sys_clk);
      rst_pulse <= 1'b1;
      repeat (n) @(posedge sys_clk);
      rst_pulse <= 1'b0;
      repeat (20) @(posedge sys_clk);
   endtask

   // first pulse is below the minimum and must be ignored
   task automatic clear_err(input logic long_min);
      pulse(long_min ? 1100 : 500);
      check(rreq, 1'b1);
      pulse(long_min ? 3600 : 1100);
      check(rreq, 1'b0);
      reg_read(`PCM_OFS_STATUS, d);
      check(d[`PCM_EVT_RST_OK], 1'b1);
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (40000) @(posedge sys_clk);
      err_count++;
      give_verdict();
   end

   initial begin
      {resetn, dis_mon, rst_pulse, reg_wr, reg_rd, go, slow} = 7'h00;
      kind = 3'h0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      repeat (5) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      reg_read(`PCM_OFS_CTRL, d);
      check(d, 32'h00000033);
      reg_read(`PCM_OFS_MASK, d);
      check(d, 32'h00000000);
      reg_read(4'h2, d);
      check(d, 32'h00000000);
      reg_write(`PCM_OFS_MASK, 32'h00000003);
      foreach (rows[i]) begin
         reg_write(`PCM_OFS_CTRL, {26'h0, rows[i].ctrl});
         reg_read(`PCM_OFS_STATUS, d);
         run_press(rows[i].kind, rows[i].slow);
         check(cerr, rows[i].cerr);
         check(oerr, rows[i].oerr);
         check(rel, !(rows[i].cerr || rows[i].oerr));
         check(irq, rows[i].cerr || rows[i].oerr);
         reg_read(`PCM_OFS_STATUS, d);
         check(d[1:0], {rows[i].oerr, rows[i].cerr});
         check(irq, 1'b0);
         if (rows[i].cerr || rows[i].oerr) clear_err(rows[i].ctrl[3]);
         check(rel, 1'b1);
         check(top_o, 1'b1);
      end
      reg_read(`PCM_OFS_STATE, d);
      check(d[3:0], 4'h1);
      // ****************************************************************
      // disable monitoring
      // ****************************************************************
      dis_mon <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check(rel, 1'b0);
      run_press(3'd1, 1'b0);
      check(cerr, 1'b0);
      dis_mon <= 1'b0;
      repeat (10) @(posedge sys_clk);
      check(rel, 1'b1);
      run_press(3'd4, 1'b0);
      check(oerr, 1'b1);
      dis_mon <= 1'b1;
      repeat (10) @(posedge sys_clk);
      check(oerr, 1'b1);
      clear_err(1'b0);
      dis_mon <= 1'b0;
      repeat (10) @(posedge sys_clk);
      check(rel, 1'b1);
      give_verdict();
   end
endmodule // testbench

bind pcm_monitor pcm_monitor_chk pcm_monitor_chk_i (.sys_clk(sys_clk),
   .resetn(resetn), .top_dead_centre_contact(top_dead_centre_contact),
   .bottom_dead_centre_contact(bottom_dead_centre_contact),
   .disable_monitoring(disable_monitoring), .reset_pulse(reset_pulse),
   .release_out(release_out), .contact_error(contact_error),
   .overrun_error(overrun_error), .reset_required(reset_required),
   .top_out(top_out), .upstroke(upstroke));
